// File: common/ssb_pkg.sv
/*
  Shared constants for the two-wire bus engine: register offsets and fields of
  the controller's APB registers, reset values and timing counts.
  Assumes a 50 MHz system clock on both ends.
*/
// Notes on behaviour
// R1 - SPI master sleep freezes transfer, resumes after
// R2 - SPI slave shifts in sleep, flags byte
// R3 - Start: SDA falls while SCL high
// R4 - Stop: SDA rises while SCL high
// R5 - Data bits change only while SCL low
// R6 - Master sends start, address, direction bit
// R7 - Direction bit one reads, zero writes
// R8 - Bytes go most significant bit first
// R9 - Receiver pulls SDA low to acknowledge
// R10 - Roles follow direction bit after address
// R11 - Slave acknowledges every written data byte
// R12 - Master acknowledges reads, stops on last
// R13 - Repeated start keeps the bus
// R14 - Lines open-drain: pull low or release
// R15 - Slave may stretch SCL; master waits
// R16 - Master starts only when bus idle
// R17 - Transmitter losing SDA compare releases SDA
// R18 - Arbitration loser releases SCL, awaits stop
// R19 - Comparison continues through data bytes
// R20 - Sample on SCL rise, change when low
// R21 - Nine-bit frame, acknowledge after eighth bit
// R22 - Synchronise SCL and SDA into clk domain
package ssb_pkg;
  // APB register offsets (byte addresses)
  localparam logic [7:0] SSB_OFF_CTRL = 8'h00;
  localparam logic [7:0] SSB_OFF_STATUS = 8'h04;
  localparam logic [7:0] SSB_OFF_TXDATA = 8'h08;
  localparam logic [7:0] SSB_OFF_RXDATA = 8'h0c;
  localparam logic [7:0] SSB_OFF_DIV = 8'h10;
  // Control field positions
  localparam int SSB_CTRL_GO = 0;
  localparam int SSB_CTRL_START = 1;
  localparam int SSB_CTRL_STOP = 2;
  localparam int SSB_CTRL_READ = 3;
  localparam int SSB_CTRL_NACK = 4;
  // Status field positions
  localparam int SSB_ST_BUSY = 0;
  localparam int SSB_ST_BUS_BUSY = 1;
  localparam int SSB_ST_ARB_LOST = 2;
  localparam int SSB_ST_RX_ACK = 3;
  localparam int SSB_ST_DONE = 4;
  // Reset values
  localparam logic [15:0] SSB_DIV_RESET = 16'h007d;
  // Timing
  localparam int SSB_CLK_MHZ = 50;
  localparam int SSB_QUARTER_NS = 2500;
  localparam int SSB_QUARTER_CYC = (SSB_QUARTER_NS * SSB_CLK_MHZ) / 1000;
  localparam int SSB_BYTE_BITS = 8;
endpackage : ssb_pkg

// File: common/ssb_bus_if.sv
/*
  Open-drain two-wire bus carrier. Each end drives enables only; the wire is
  low while any enable is high (wired-AND with pull-up).
*/
`timescale 1ns/1ps
interface ssb_bus_if;
  logic scl_m_oe;
  logic sda_m_oe;
  logic scl_s_oe;
  logic sda_s_oe;
  logic scl;
  logic sda;
  // Wired-AND resolution of the two ends
  assign scl = ~(scl_m_oe | scl_s_oe);
  assign sda = ~(sda_m_oe | sda_s_oe);
  modport master (input scl, input sda, output scl_m_oe, output sda_m_oe);
  modport slave (input scl, input sda, output scl_s_oe, output sda_s_oe);
endinterface : ssb_bus_if

// File: hdl/ssb_line_sync.sv
/*
  Two-stage synchroniser for SCL and SDA plus bus condition detection.
  Assumes inputs are asynchronous to clk.
*/
`timescale 1ns/1ps
module ssb_line_sync
  import ssb_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Raw lines
  input wire logic scl_in,
  input wire logic sda_in,
  // Synchronised view
  output logic scl_s,
  output logic sda_s,
  output logic scl_rise,
  output logic scl_fall,
  output logic start_det,
  output logic stop_det,
  output logic bus_busy
);
  logic [1:0] scl_ff_reg;
  logic [1:0] sda_ff_reg;
  logic scl_d_reg;
  logic sda_d_reg;

  // Two flops before any logic
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      scl_ff_reg <= 2'h3;
      sda_ff_reg <= 2'h3;
    end else begin
      scl_ff_reg <= {scl_ff_reg[0], scl_in}; // R22
      sda_ff_reg <= {sda_ff_reg[0], sda_in}; // R22
    end
  end

  // Delayed copies for edges
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_ff_reg[1];
      sda_d_reg <= sda_ff_reg[1];
    end
  end

  // Edge and condition decode
  assign scl_s = scl_ff_reg[1];
  assign sda_s = sda_ff_reg[1];
  assign scl_rise = scl_ff_reg[1] & ~scl_d_reg; // R20
  assign scl_fall = ~scl_ff_reg[1] & scl_d_reg;
  assign start_det = scl_ff_reg[1] & scl_d_reg & sda_d_reg & ~sda_ff_reg[1]; // R3
  assign stop_det = scl_ff_reg[1] & scl_d_reg & ~sda_d_reg & sda_ff_reg[1]; // R4

  // Busy between start and stop
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bus_busy <= 1'b0;
    end else if (start_det) begin
      bus_busy <= 1'b1; // R16
    end else if (stop_det) begin
      bus_busy <= 1'b0;
    end
  end
endmodule : ssb_line_sync

// File: hdl/ssb_master.sv
/*
  Bus master end: APB-programmed byte engine issuing start, address/data
  bytes, acknowledge, repeated start and stop, with stretching and arbitration.
  Assumes an APB master on clk and the shared open-drain bus interface.
*/
// The implementer's own choices: the APB register port and the register offsets.
`timescale 1ns/1ps
module ssb_master
  import ssb_pkg::*;
#(
  parameter int DIV_WIDTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Sleep request (freezes engine)
  input wire logic sleep_req,
  // Bus
  ssb_bus_if.master bus
);
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0, ST_START = 4'h1, ST_LOW = 4'h3, ST_HIGH = 4'h2,
    ST_ACK_LOW = 4'h6, ST_ACK_HIGH = 4'h7, ST_STOP_A = 4'h5, ST_STOP_B = 4'h4,
    ST_RS = 4'hc
  } ssb_mst_state_t;

  // Divider widths the counter and DIV register can serve
  if (DIV_WIDTH < 4 || DIV_WIDTH > 16) begin : g_bad_div_width
    $error("DIV_WIDTH out of range");
  end

  ssb_mst_state_t state_reg;
  logic scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det, bus_busy;
  logic [DIV_WIDTH-1:0] div_reg, cnt_reg;
  logic [7:0] tx_reg, rx_reg, shift_reg;
  logic [3:0] bit_reg;
  logic go_reg, start_req_reg, stop_req_reg, read_reg, nack_reg;
  logic arb_lost_reg, rx_ack_reg, done_reg, busy_reg;
  logic scl_oe_reg, sda_oe_reg;
  logic tick;
  logic wr_en;
  logic rd_en;

  ssb_line_sync u_sync (
    .clk(clk), .reset_n(reset_n), .scl_in(bus.scl), .sda_in(bus.sda),
    .scl_s(scl_s), .sda_s(sda_s), .scl_rise(scl_rise), .scl_fall(scl_fall),
    .start_det(start_det), .stop_det(stop_det), .bus_busy(bus_busy)
  );

  assign bus.scl_m_oe = scl_oe_reg; // R14
  assign bus.sda_m_oe = sda_oe_reg; // R14
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & ~penable & ~pwrite;
  // Bit-phase tick, three per bit; frozen while asleep
  assign tick = (cnt_reg == '0) & ~sleep_req; // R1

  // Tick divider, three ticks per bit; free running so an idle engine still gets ticks
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_reg <= '0;
    end else if (sleep_req) begin
      cnt_reg <= cnt_reg; // R1
    end else if (cnt_reg == '0) begin
      cnt_reg <= div_reg;
    end else begin
      cnt_reg <= cnt_reg - 1'b1;
    end
  end

  // APB register writes
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      div_reg <= DIV_WIDTH'(SSB_DIV_RESET);
      tx_reg <= 8'h00;
      start_req_reg <= 1'b0;
      stop_req_reg <= 1'b0;
      read_reg <= 1'b0;
      nack_reg <= 1'b0;
    end else if (wr_en && paddr == SSB_OFF_CTRL) begin
      start_req_reg <= pwdata[SSB_CTRL_START];
      stop_req_reg <= pwdata[SSB_CTRL_STOP];
      read_reg <= pwdata[SSB_CTRL_READ];
      nack_reg <= pwdata[SSB_CTRL_NACK];
    end else if (wr_en && paddr == SSB_OFF_TXDATA) begin
      tx_reg <= pwdata[7:0];
    end else if (wr_en && paddr == SSB_OFF_DIV) begin
      div_reg <= pwdata[DIV_WIDTH-1:0];
    end
  end

  // APB read path and answer (no wait states)
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~(paddr == SSB_OFF_CTRL || paddr == SSB_OFF_STATUS ||
                 paddr == SSB_OFF_TXDATA || paddr == SSB_OFF_RXDATA || paddr == SSB_OFF_DIV);
      if (rd_en) begin
        if (paddr == SSB_OFF_STATUS) begin
          prdata <= {27'h0, done_reg, rx_ack_reg, arb_lost_reg, bus_busy, busy_reg};
        end else if (paddr == SSB_OFF_RXDATA) begin
          prdata <= {24'h0, rx_reg};
        end else if (paddr == SSB_OFF_TXDATA) begin
          prdata <= {24'h0, tx_reg};
        end else if (paddr == SSB_OFF_DIV) begin
          prdata <= {{(32-DIV_WIDTH){1'b0}}, div_reg};
        end else if (paddr == SSB_OFF_CTRL) begin
          prdata <= {27'h0, nack_reg, read_reg, stop_req_reg, start_req_reg, go_reg};
        end else begin
          prdata <= 32'h0000_0000;
        end
      end
    end
  end

  // Byte engine
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= ST_IDLE;
      scl_oe_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      shift_reg <= 8'h00;
      rx_reg <= 8'h00;
      bit_reg <= 4'h0;
      go_reg <= 1'b0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      arb_lost_reg <= 1'b0;
      rx_ack_reg <= 1'b0;
    end else begin
      if (wr_en && paddr == SSB_OFF_CTRL && pwdata[SSB_CTRL_GO]) begin
        go_reg <= 1'b1;
        done_reg <= 1'b0;
        arb_lost_reg <= 1'b0;
      end
      case (state_reg)
        ST_IDLE: begin
          if (go_reg && !(start_req_reg && bus_busy && !scl_oe_reg) && tick) begin // R16
            go_reg <= 1'b0;
            busy_reg <= 1'b1;
            shift_reg <= tx_reg;
            bit_reg <= 4'h0;
            if (start_req_reg && scl_oe_reg) begin
              state_reg <= ST_RS; // R13
            end else if (start_req_reg) begin
              state_reg <= ST_START;
            end else begin
              state_reg <= ST_LOW;
            end
          end
        end
        ST_RS: if (tick) begin
          sda_oe_reg <= 1'b0; // Release SDA while SCL low
          if (!sda_oe_reg) scl_oe_reg <= 1'b0; // R5
          if (!scl_oe_reg && scl_s && sda_s) state_reg <= ST_START; // R15
        end
        ST_START: if (tick) begin
          sda_oe_reg <= 1'b1; // R3 R6
          state_reg <= ST_LOW;
        end
        ST_LOW: if (tick) begin
          scl_oe_reg <= 1'b1;
          if (scl_oe_reg) begin
            sda_oe_reg <= read_reg ? 1'b0 : ~shift_reg[7]; // R5 R8 R10
            state_reg <= ST_HIGH;
          end
        end
        ST_HIGH: if (tick) begin
          scl_oe_reg <= 1'b0;
          if (!scl_oe_reg && scl_s) begin // R15
            if (!read_reg && !sda_oe_reg && !sda_s) begin
              arb_lost_reg <= 1'b1; // R17 R19
              sda_oe_reg <= 1'b0;
              busy_reg <= 1'b0;
              done_reg <= 1'b1;
              state_reg <= ST_IDLE; // R18
            end else begin
              shift_reg <= {shift_reg[6:0], sda_s}; // R20
              bit_reg <= bit_reg + 4'h1;
              scl_oe_reg <= 1'b1;
              state_reg <= (bit_reg == 4'(SSB_BYTE_BITS - 1)) ? ST_ACK_LOW : ST_LOW;
            end
          end
        end
        ST_ACK_LOW: if (tick) begin
          sda_oe_reg <= read_reg & ~nack_reg; // R9 R12 R21
          if (read_reg) rx_reg <= shift_reg;
          state_reg <= ST_ACK_HIGH;
        end
        ST_ACK_HIGH: if (tick) begin
          scl_oe_reg <= 1'b0;
          if (!scl_oe_reg && scl_s) begin // R15
            if (!read_reg) rx_ack_reg <= ~sda_s; // R9 R11
            scl_oe_reg <= 1'b1;
            state_reg <= stop_req_reg ? ST_STOP_A : ST_IDLE;
            if (!stop_req_reg) begin
              busy_reg <= 1'b0;
              done_reg <= 1'b1;
            end
          end
        end
        ST_STOP_A: if (tick) begin
          sda_oe_reg <= 1'b1; // Hold SDA low under SCL low
          scl_oe_reg <= ~scl_oe_reg ? 1'b0 : scl_oe_reg;
          if (sda_oe_reg) begin
            scl_oe_reg <= 1'b0;
            if (scl_s) state_reg <= ST_STOP_B; // R15
          end
        end
        ST_STOP_B: if (tick) begin
          sda_oe_reg <= 1'b0; // R4 R12
          busy_reg <= 1'b0;
          done_reg <= 1'b1;
          state_reg <= ST_IDLE;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end
endmodule : ssb_master

// File: hdl/ssb_slave.sv
/*
  Bus slave end: receives address and data, acknowledges, transmits on reads,
  stretches SCL until the user supplies data. Address matching is left to the
  user side; every address is acknowledged.
*/
`timescale 1ns/1ps
module ssb_slave
  import ssb_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // User side
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic addr_valid,
  output logic irq_flag,
  input wire logic irq_clear,
  // Bus
  ssb_bus_if.slave bus
);
  typedef enum logic [2:0] {
    SV_IDLE = 3'h0, SV_BITS = 3'h1, SV_ACK = 3'h3, SV_ACK_END = 3'h2, SV_STRETCH = 3'h6, SV_RELEASE = 3'h7
  } ssb_slv_state_t;

  ssb_slv_state_t state_reg;
  logic scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det, bus_busy;
  logic [7:0] shift_reg;
  logic [3:0] bit_reg;
  logic is_addr_reg, reading_reg, master_ack_reg;
  logic scl_oe_reg, sda_oe_reg;

  ssb_line_sync u_sync (
    .clk(clk), .reset_n(reset_n), .scl_in(bus.scl), .sda_in(bus.sda),
    .scl_s(scl_s), .sda_s(sda_s), .scl_rise(scl_rise), .scl_fall(scl_fall),
    .start_det(start_det), .stop_det(stop_det), .bus_busy()
  );

  assign bus.scl_s_oe = scl_oe_reg; // R14
  assign bus.sda_s_oe = sda_oe_reg; // R14

  // Byte flag: set beats clear
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_flag <= 1'b0;
    end else if (rx_valid) begin
      irq_flag <= 1'b1; // R2
    end else if (irq_clear) begin
      irq_flag <= 1'b0;
    end
  end

  // Protocol engine
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= SV_IDLE;
      shift_reg <= 8'h00;
      bit_reg <= 4'h0;
      is_addr_reg <= 1'b0;
      reading_reg <= 1'b0;
      master_ack_reg <= 1'b0;
      scl_oe_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      rx_data <= 8'h00;
      rx_valid <= 1'b0;
      addr_valid <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      addr_valid <= 1'b0;
      if (start_det) begin
        state_reg <= SV_BITS; // R13
        bit_reg <= 4'h0;
        is_addr_reg <= 1'b1;
        reading_reg <= 1'b0;
        sda_oe_reg <= 1'b0;
        scl_oe_reg <= 1'b0;
      end else if (stop_det) begin
        state_reg <= SV_IDLE;
        sda_oe_reg <= 1'b0;
        scl_oe_reg <= 1'b0;
      end else begin
        case (state_reg)
          SV_IDLE: ;
          SV_BITS: begin
            if (scl_rise) begin
              shift_reg <= {shift_reg[6:0], sda_s}; // R8 R20
              bit_reg <= bit_reg + 4'h1;
            end else if (scl_fall) begin
              if (bit_reg == 4'(SSB_BYTE_BITS)) begin
                state_reg <= SV_ACK;
                if (is_addr_reg) begin
                  reading_reg <= shift_reg[0]; // R7 R10
                  rx_data <= shift_reg;
                  addr_valid <= 1'b1;
                  sda_oe_reg <= 1'b1; // R9
                end else if (!reading_reg) begin
                  rx_data <= shift_reg;
                  rx_valid <= 1'b1;
                  sda_oe_reg <= 1'b1; // R11
                end else begin
                  sda_oe_reg <= 1'b0; // R21
                end
              end else if (reading_reg && !is_addr_reg) begin
                sda_oe_reg <= ~shift_reg[7]; // R5 R8
              end
            end
          end
          SV_ACK: if (scl_rise) begin
            master_ack_reg <= ~sda_s; // R12
            state_reg <= SV_ACK_END;
          end
          SV_ACK_END: if (scl_fall) begin
            sda_oe_reg <= 1'b0;
            bit_reg <= 4'h0;
            is_addr_reg <= 1'b0;
            if (reading_reg && (is_addr_reg || master_ack_reg)) begin
              scl_oe_reg <= 1'b1; // R15
              state_reg <= SV_STRETCH;
            end else if (reading_reg) begin
              state_reg <= SV_IDLE; // Master ended the read
            end else begin
              state_reg <= SV_BITS;
            end
          end
          SV_STRETCH: if (tx_valid) begin
            sda_oe_reg <= ~tx_data[7]; // R8 R10
            shift_reg <= tx_data;
            state_reg <= SV_RELEASE; // R5
          end
          // First data bit settles a cycle before SCL is let go
          SV_RELEASE: begin
            scl_oe_reg <= 1'b0; // R15
            state_reg <= SV_BITS;
          end
          default: state_reg <= SV_IDLE;
        endcase
      end
    end
  end
endmodule : ssb_slave

// File: bench/ssb_assertions.sv
/* Bus-level checks on the wired bus joining master and slave.
   Assumes the bench places it beside that bus and sets a small divider. */
`timescale 1ns/1ps
module ssb_assertions (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Bus lines and enables
  input wire logic scl,
  input wire logic sda,
  input wire logic scl_m_oe,
  input wire logic sda_m_oe,
  input wire logic scl_s_oe,
  input wire logic sda_s_oe
);
  logic scl_q;
  logic sda_q;
  logic busy_q;
  logic first_q;
  logic [3:0] bit_cnt;
  logic start_c;
  logic stop_c;
  logic rise_c;
  // Conditions seen on the raw lines
  assign start_c = scl && scl_q && sda_q && !sda;
  assign stop_c = scl && scl_q && !sda_q && sda;
  assign rise_c = scl && !scl_q;
  // Line history
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end
  // Bus ownership and bit position in the frame
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      busy_q <= 1'b0;
      first_q <= 1'b0;
      bit_cnt <= 4'h0;
    end else if (start_c) begin
      busy_q <= 1'b1;
      first_q <= 1'b1;
      bit_cnt <= 4'h0;
    end else if (stop_c) begin
      busy_q <= 1'b0;
    end else if (rise_c) begin
      bit_cnt <= (bit_cnt == 4'h8) ? 4'h0 : bit_cnt + 4'h1;
      first_q <= first_q && (bit_cnt != 4'h8);
    end
  end
  default clocking dcb @(posedge clk); endclocking
  default disable iff (!reset_n);
  chk_slave_data_low: assert property (
    $changed(sda_s_oe) |-> !scl) else $error("slave moved data with clock high");
  chk_slave_no_cond: assert property (
    scl && $past(scl) && $changed(sda) |-> $stable(sda_s_oe)) else $error("slave made a condition");
  chk_stretch_low: assert property (
    $rose(scl_s_oe) |-> !$past(scl)) else $error("stretch began with clock high");
  chk_stretch_resume: assert property (
    $fell(scl_s_oe) |-> ##[1:600] scl) else $error("master did not resume after stretch");
  chk_addr_acked: assert property (
    rise_c && first_q && bit_cnt == 4'h8 |-> !sda) else $error("address not acknowledged");
  chk_ack_released: assert property (
    rise_c && first_q && bit_cnt == 4'h8 |-> !sda_m_oe) else $error("master held data in ack slot");
  chk_start_clocks: assert property (
    start_c |-> ##[1:600] !scl) else $error("no clocking after start");
  chk_stop_quiet: assert property (
    stop_c |=> (!scl_m_oe && !sda_m_oe) [*3]) else $error("master drove after stop");
  chk_idle_no_clock: assert property (
    !busy_q |-> !scl_m_oe) else $error("master clocked an idle bus");
endmodule : ssb_assertions

// File: bench/sync_serial_i2c_bus_engine_tb_top.sv
/* Bench: master and slave on one bus; a second master on a bus whose far
   end the bench drives. Assumes 50 MHz and a divider of 4. */
`timescale 1ns/1ps
module sync_serial_i2c_bus_engine_tb_top import ssb_pkg::*;;
  localparam logic [31:0] c_go = 32'h1 << SSB_CTRL_GO;
  localparam logic [31:0] c_start = 32'h1 << SSB_CTRL_START;
  localparam logic [31:0] c_stop = 32'h1 << SSB_CTRL_STOP;
  localparam logic [31:0] c_read = 32'h1 << SSB_CTRL_READ;
  localparam logic [31:0] c_nack = 32'h1 << SSB_CTRL_NACK;
  // Rows: bit 8 marks an address byte after start, low byte is sent and expected back
  localparam logic [8:0] rows [5] = '{9'h1a4, 9'h05a, 9'h081, 9'h000, 9'h0ff};
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [1:0] psel = 2'b00;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata_a, prdata_b, rd;
  logic pready_a, pready_b, pslverr_a, pslverr_b, err;
  logic sleep_req = 1'b0;
  logic [7:0] tx_data = 8'h00;
  logic tx_valid = 1'b1;
  logic irq_clear = 1'b0;
  logic [7:0] rx_data, cap_addr, cap_data;
  logic rx_valid, addr_valid, irq_flag;
  logic [8:0] mon_sh, mon_frame;
  logic [3:0] mon_cnt = 4'h0;
  int fails = 0;
  int n_tests = 0;
  ssb_bus_if bus_a ();
  ssb_bus_if bus_b ();
  always #10 clk = ~clk;
  ssb_master ssb_master_inst (.clk(clk), .reset_n(reset_n), .psel(psel[0]), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata_a), .pready(pready_a),
    .pslverr(pslverr_a), .sleep_req(sleep_req), .bus(bus_a));
  ssb_master ssb_master_inst_b (.clk(clk), .reset_n(reset_n), .psel(psel[1]), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata_b), .pready(pready_b),
    .pslverr(pslverr_b), .sleep_req(1'b0), .bus(bus_b));
  ssb_slave ssb_slave_inst (.clk(clk), .reset_n(reset_n), .tx_data(tx_data), .tx_valid(tx_valid),
    .rx_data(rx_data), .rx_valid(rx_valid), .addr_valid(addr_valid), .irq_flag(irq_flag),
    .irq_clear(irq_clear), .bus(bus_a));
  ssb_assertions ssb_assertions_inst (.clk(clk), .reset_n(reset_n), .scl(bus_a.scl), .sda(bus_a.sda),
    .scl_m_oe(bus_a.scl_m_oe), .sda_m_oe(bus_a.sda_m_oe), .scl_s_oe(bus_a.scl_s_oe),
    .sda_s_oe(bus_a.sda_s_oe));
  // Wire monitor: nine-bit frames counted from each start
  always @(negedge bus_a.sda) if (bus_a.scl === 1'b1) mon_cnt = 4'h0;
  always @(posedge bus_a.scl) begin
    mon_sh = {mon_sh[7:0], bus_a.sda};
    mon_cnt = mon_cnt + 4'h1;
    if (mon_cnt == 4'h9) begin
      mon_frame = mon_sh;
      mon_cnt = 4'h0;
    end
  end
  // Slave user side capture
  always @(posedge clk) begin
    if (addr_valid === 1'b1) cap_addr <= rx_data;
    if (rx_valid === 1'b1) cap_data <= rx_data;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic give_up();
    fails++;
    tally_and_finish();
  endtask : give_up
  // One APB transfer on master m, waits for pready
  task automatic apb(input int m, input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel[m] <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if ((m ? pready_b : pready_a) === 1'b1) break;
    end
    if (i == 20) give_up();
    rd = m ? prdata_b : prdata_a;
    err = m ? pslverr_b : pslverr_a;
    psel <= 2'b00;
    penable <= 1'b0;
  endtask : apb
  task automatic wait_bit(input int m, input int b);
    int i;
    for (i = 0; i < 400; i++) begin
      apb(m, 1'b0, SSB_OFF_STATUS, 32'h0);
      if (rd[b] === 1'b1) break;
    end
    if (i == 400) give_up();
  endtask : wait_bit
  task automatic go(input int m, input logic [31:0] ctrl, input logic [7:0] tx);
    apb(m, 1'b1, SSB_OFF_TXDATA, {24'h0, tx});
    apb(m, 1'b1, SSB_OFF_CTRL, ctrl | c_go);
  endtask : go
  task automatic xfer(input int m, input logic [31:0] ctrl, input logic [7:0] tx);
    go(m, ctrl, tx);
    wait_bit(m, SSB_ST_DONE);
  endtask : xfer
  // Main sequence
  initial begin
    int i;
    logic [5:0] s;
    bus_b.scl_s_oe <= 1'b0;
    bus_b.sda_s_oe <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    apb(0, 1'b0, SSB_OFF_DIV, 32'h0);
    check(rd, {16'h0, SSB_DIV_RESET});
    apb(0, 1'b0, SSB_OFF_STATUS, 32'h0);
    check(rd, 32'h0);
    apb(0, 1'b0, 8'h14, 32'h0);
    check({rd[30:0], err}, 32'h1);
    apb(0, 1'b1, SSB_OFF_DIV, 32'h4);
    apb(1, 1'b1, SSB_OFF_DIV, 32'h4);
    $display("test registers done");
    for (int k = 0; k < 5; k++) begin
      xfer(0, rows[k][8] ? c_start : 32'h0, rows[k][7:0]);
      check(rows[k][8] ? cap_addr : cap_data, rows[k][7:0]);
      check(mon_frame, {rows[k][7:0], 1'b0});
      apb(0, 1'b0, SSB_OFF_STATUS, 32'h0);
      check(rd[SSB_ST_RX_ACK], 1'b1);
    end
    check(irq_flag, 1'b1);
    irq_clear <= 1'b1;
    @(posedge clk);
    irq_clear <= 1'b0;
    @(posedge clk);
    check(irq_flag, 1'b0);
    $display("test write done");
    tx_valid <= 1'b0;
    xfer(0, c_start, 8'ha5);
    check(mon_frame, 9'h14a);
    go(0, c_read, 8'h00);
    repeat (300) @(posedge clk);
    check({bus_a.scl, bus_a.scl_s_oe}, 2'b01);
    tx_data <= 8'hc3;
    tx_valid <= 1'b1;
    for (i = 0; i < 400 && bus_a.scl_s_oe !== 1'b0; i++) @(posedge clk);
    if (i == 400) give_up();
    tx_valid <= 1'b0;
    wait_bit(0, SSB_ST_DONE);
    apb(0, 1'b0, SSB_OFF_RXDATA, 32'h0);
    check(rd, 32'hc3);
    check(mon_frame, 9'h186);
    tx_data <= 8'h3c;
    tx_valid <= 1'b1;
    xfer(0, c_read | c_nack | c_stop, 8'h00);
    apb(0, 1'b0, SSB_OFF_RXDATA, 32'h0);
    check(rd, 32'h3c);
    check(mon_frame, 9'h079);
    apb(0, 1'b0, SSB_OFF_STATUS, 32'h0);
    check(rd[SSB_ST_BUS_BUSY], 1'b0);
    $display("test read done");
    go(0, c_start, 8'hb6);
    repeat (60) @(posedge clk);
    sleep_req <= 1'b1;
    repeat (2) @(posedge clk);
    s = {bus_a.scl, bus_a.sda, mon_cnt};
    repeat (200) @(posedge clk);
    check({bus_a.scl, bus_a.sda, mon_cnt}, s);
    sleep_req <= 1'b0;
    wait_bit(0, SSB_ST_DONE);
    check(mon_frame, 9'h16c);
    xfer(0, c_stop, 8'h11);
    check(cap_data, 8'h11);
    $display("test sleep done");
    bus_b.sda_s_oe <= 1'b1;
    repeat (10) @(posedge clk);
    bus_b.scl_s_oe <= 1'b1;
    go(1, c_start, 8'h80);
    repeat (200) @(posedge clk);
    check({bus_b.scl_m_oe, bus_b.sda_m_oe}, 2'b00);
    bus_b.scl_s_oe <= 1'b0;
    repeat (10) @(posedge clk);
    bus_b.sda_s_oe <= 1'b0;
    for (i = 0; i < 400 && bus_b.scl !== 1'b0; i++) @(posedge clk);
    if (i == 400) give_up();
    bus_b.sda_s_oe <= 1'b1;
    wait_bit(1, SSB_ST_ARB_LOST);
    repeat (4) @(posedge clk);
    check({bus_b.scl_m_oe, bus_b.sda_m_oe}, 2'b00);
    bus_b.sda_s_oe <= 1'b0;
    $display("test arbitration done");
    tally_and_finish();
  end
endmodule : sync_serial_i2c_bus_engine_tb_top
